/* File: psl_monitor.v */
// Per-port status LED drivers, negotiation status flags and quick status
`timescale 1ns/1ps
`include "psl_defines.vh"
module psl_monitor #(
	parameter MS_CYCLES = `PSL_MS_CYC
) (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// Port conditions, same clock domain
	input  wire        link_up,
	input  wire        speed_100,
	input  wire        duplex_full,
	input  wire        tx_active,
	input  wire        rx_active,
	input  wire        collision,
	input  wire        polarity_ok,
	// Negotiation events, same clock domain
	input  wire        an_complete,
	input  wire        an_start,
	input  wire        page_rx_evt,
	input  wire        base_page_evt,
	input  wire        page_flags_read,
	// LED and page-flag configuration
	input  wire [3:0]  led1_sel,
	input  wire [3:0]  led2_sel,
	input  wire [3:0]  led3_sel,
	input  wire        stretch_en,
	input  wire [1:0]  stretch_len,
	input  wire        alt_next_page_en,
	input  wire        hw_ctrl_mode,
	// Status flags
	output reg         an_done,
	output reg         link_status_basic,
	output reg         link_status_quick,
	output reg         page_received,
	output reg         base_page,
	// LED pins
	input  wire [2:0]  led_in,
	output reg  [2:0]  led_out,
	output reg  [2:0]  led_oe,
	output reg  [2:0]  hw_strap,
	// Quick-status link
	input  wire        status_shift_clock,
	output wire        status_serial_out
);
	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Condition picked by one LED selection field
	function led_cond;
		input [3:0] sel;
		input       blink;
		begin
			// Codes left unassigned read as off
			case (sel)
				`PSL_SEL_SPEED:   led_cond = speed_100;
				`PSL_SEL_TX:      led_cond = tx_active;
				`PSL_SEL_RX:      led_cond = rx_active;
				`PSL_SEL_COL:     led_cond = collision;
				`PSL_SEL_LINK:    led_cond = link_up;
				`PSL_SEL_DUPLEX:  led_cond = duplex_full;
				`PSL_SEL_LINKACT: led_cond = blink;
				`PSL_SEL_ON:      led_cond = 1'b1;
				default:          led_cond = 1'b0;
			endcase
		end
	endfunction

	// Stretch interval in milliseconds
	function [6:0] str_ms;
		input [1:0] code;
		begin
			case (code)
				`PSL_STR_CODE_30: str_ms = `PSL_STR_30_MS;
				`PSL_STR_CODE_60: str_ms = `PSL_STR_60_MS;
				default:          str_ms = `PSL_STR_100_MS;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [31:0] ms_div_r;
	reg         ms_tick_r;
	reg  [9:0]  lamp_cnt_r;
	reg         lamp_on_r;
	reg  [6:0]  blink_cnt_r;
	reg         blink_ph_r;
	reg  [3:0]  strap_cnt_r;
	reg         strap_done_r;
	reg  [2:0]  strap_m_r;
	reg  [2:0]  strap_s_r;
	reg         link_act_r;
	wire [6:0]  len_ms;
	wire        activity;
	wire        linkact_view;
	wire [2:0]  cond;
	wire [2:0]  stretched;
	wire [15:0] qs_word;

	// Stretch length shared by the three stretchers and the blink timer
	assign len_ms   = str_ms(stretch_len);
	assign activity = tx_active | rx_active | collision;

	// ----------------------------------------
	// Millisecond enable
	// ----------------------------------------
	// One tick per millisecond keeps every long timer narrow
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ms_div_r  <= 32'h00000000;
			ms_tick_r <= 1'b0;
		end
		else if (ms_div_r == MS_CYCLES - 1)
		begin
			ms_div_r  <= 32'h00000000;
			ms_tick_r <= 1'b1;
		end
		else
		begin
			ms_div_r  <= ms_div_r + 32'h00000001;
			ms_tick_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Power-up lamp test
	// ----------------------------------------
	// LEDs held on until the millisecond count reaches one second
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lamp_cnt_r <= 10'h000;
			lamp_on_r  <= 1'b1;
		end
		else if (lamp_on_r && ms_tick_r)
		begin
			if (lamp_cnt_r == `PSL_LAMP_MS - 1)
				lamp_on_r <= 1'b0;
			lamp_cnt_r <= lamp_cnt_r + 10'h001;
		end
	end

	// ----------------------------------------
	// Link and activity blink
	// ----------------------------------------
	// Phase toggles each stretch interval while activity persists
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			blink_cnt_r <= 7'h00;
			blink_ph_r  <= 1'b0;
			link_act_r  <= 1'b0;
		end
		else
		begin
			link_act_r <= link_up & activity;
			if (!(link_up & activity))
			begin
				blink_cnt_r <= 7'h00;
				blink_ph_r  <= 1'b0;
			end
			else if (ms_tick_r)
			begin
				if (blink_cnt_r >= len_ms - 7'h01)
				begin
					blink_cnt_r <= 7'h00;
					blink_ph_r  <= ~blink_ph_r;
				end
				else
					blink_cnt_r <= blink_cnt_r + 7'h01;
			end
		end
	end

	// Off without link, on with link, dark phase only during activity
	assign linkact_view = link_up & ~(link_act_r & blink_ph_r);

	// ----------------------------------------
	// Per-LED selection and stretching
	// ----------------------------------------
	assign cond[0] = led_cond(led1_sel, linkact_view);
	assign cond[1] = led_cond(led2_sel, linkact_view);
	assign cond[2] = led_cond(led3_sel, linkact_view);

	// One stretcher per LED keeps the three timers independent
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_led
			// Blink code passes through the stretcher like every other selection
			psl_stretch u_str (
				.clk        (clk),
				.resetn     (resetn),
				.ms_tick    (ms_tick_r),
				.stretch_en (stretch_en),
				.len_ms     (len_ms),
				.evt        (cond[gi]),
				.led        (stretched[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Hardware-control straps on the LED pins
	// ----------------------------------------
	// In hardware-control mode pins float briefly after reset so the strap level can be read
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			strap_cnt_r  <= 4'h0;
			strap_done_r <= 1'b0;
			strap_m_r    <= 3'h0;
			strap_s_r    <= 3'h0;
			hw_strap     <= 3'h0;
		end
		else
		begin
			strap_m_r <= led_in;
			strap_s_r <= strap_m_r;
			if (!strap_done_r)
			begin
				strap_cnt_r <= strap_cnt_r + 4'h1;
				if (strap_cnt_r == `PSL_STRAP_CYC)
				begin
					strap_done_r <= 1'b1;
					hw_strap     <= strap_s_r;
				end
			end
		end
	end

	// ----------------------------------------
	// LED pin drive
	// ----------------------------------------
	// Lamp test overrides every LED; drivers stay off during the strap window in hardware-control mode
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			led_out <= 3'h7;
			led_oe  <= 3'h0;
		end
		else
		begin
			led_out <= stretched | {3{lamp_on_r}};
			led_oe  <= (hw_ctrl_mode && !strap_done_r) ? 3'h0 : 3'h7;
		end
	end

	// ----------------------------------------
	// Negotiation and link flags
	// ----------------------------------------
	// Set wins over a read clear arriving in the same cycle
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			an_done           <= 1'b0;
			link_status_basic <= 1'b0;
			link_status_quick <= 1'b0;
			page_received     <= 1'b0;
			base_page         <= 1'b0;
		end
		else
		begin
			an_done           <= an_complete;
			link_status_basic <= link_up;
			link_status_quick <= link_up;
			// Page flag: set, then cleared by a read or an alternate-mode restart
			if (page_rx_evt)
				page_received <= 1'b1;
			else if (page_flags_read)
				page_received <= 1'b0;
			else if (alt_next_page_en && an_start)
				page_received <= 1'b0;
			// Base page flag: set, then cleared by a read
			if (base_page_evt)
				base_page <= 1'b1;
			else if (page_flags_read)
				base_page <= 1'b0;
		end
	end

	// ----------------------------------------
	// Quick-status stream
	// ----------------------------------------
	// Bit 5 carries polarity; bits 4:0 read as zero
	assign qs_word = {
		rx_active,     // Bit 15
		tx_active,
		collision,
		link_up,
		duplex_full,
		speed_100,
		an_done,
		page_received,
		base_page,
		an_start,
		polarity_ok,
		5'h00          // Bits 4:0 spare
	};

	psl_status_serial_out u_qs (
		.clk                (clk),
		.resetn             (resetn),
		.status_shift_clock (status_shift_clock),
		.qs_word            (qs_word),
		.status_serial_out  (status_serial_out)
	);
endmodule // psl_monitor

/* File: psl_defines.vh */
// Constants of the status LED and quick-status monitor
`ifndef PSL_DEFINES_VH
`define PSL_DEFINES_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define PSL_CLK_NS      25
`define PSL_MS_NS       1000000
`define PSL_MS_CYC      (`PSL_MS_NS / `PSL_CLK_NS)
`define PSL_LAMP_MS     1000
`define PSL_STR_30_MS   7'h1E
`define PSL_STR_60_MS   7'h3C
`define PSL_STR_100_MS  7'h64
`define PSL_STRAP_CYC   4'h8
// ----------------------------------------
// Stretch length codes
// ----------------------------------------
`define PSL_STR_CODE_30  2'h0
`define PSL_STR_CODE_60  2'h1
`define PSL_STR_CODE_100 2'h2
// ----------------------------------------
// LED selection codes
// ----------------------------------------
`define PSL_SEL_SPEED   4'h0
`define PSL_SEL_TX      4'h1
`define PSL_SEL_RX      4'h2
`define PSL_SEL_COL     4'h3
`define PSL_SEL_LINK    4'h4
`define PSL_SEL_DUPLEX  4'h5
`define PSL_SEL_LINKACT 4'hD
`define PSL_SEL_ON      4'hE
// ----------------------------------------
// Quick-status frame
// ----------------------------------------
`define PSL_QS_BITS     5'h10
`define PSL_QS_LAST     5'h1F
`endif

/* File: psl_stretch.v */
// Retriggerable LED pulse stretcher for one LED output
`timescale 1ns/1ps
module psl_stretch (
	// Clock and reset
	input  wire       clk,
	input  wire       resetn,
	// Control
	input  wire       ms_tick,
	input  wire       stretch_en,
	input  wire [6:0] len_ms,
	// Event and result
	input  wire       evt,
	output wire       led
);
	reg        armed_prev_r;
	reg  [6:0] timer_r;
	wire       evt_edge;
	wire       expire;

	assign evt_edge = evt & ~armed_prev_r;
	assign expire   = ms_tick & (timer_r == 7'h01);

	// ----------------------------------------
	// Edge detector and stretch timer
	// ----------------------------------------
	// Reloading the timer on expiry lets a standing event retrigger
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			armed_prev_r <= 1'b0;
			timer_r      <= 7'h00;
		end
		else if (!stretch_en)
		begin
			armed_prev_r <= 1'b0;
			timer_r      <= 7'h00;
		end
		else if (evt_edge)
		begin
			armed_prev_r <= 1'b1;
			timer_r      <= len_ms;
		end
		else if (expire)
		begin
			// Rearm; a standing event retriggers at once, leaving no dark cycle
			armed_prev_r <= evt;
			timer_r      <= evt ? len_ms : 7'h00;
		end
		else
		begin
			armed_prev_r <= armed_prev_r & evt;
			if (ms_tick && timer_r != 7'h00)
				timer_r <= timer_r - 7'h01;
		end
	end

	// Plain follow when stretching is off
	assign led = stretch_en ? (timer_r != 7'h00) : evt;
endmodule // psl_stretch

/* File: psl_status_serial_out.v */
// Quick-status serializer driven by the external shift clock
`timescale 1ns/1ps
module psl_status_serial_out (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// Shift clock pin and word
	input  wire        status_shift_clock,
	input  wire [15:0] qs_word,
	// Serial output
	output reg         status_serial_out
);
	reg         sclk_m_r;
	reg         sclk_s_r;
	reg         sclk_d_r;
	reg  [4:0]  pos_r;
	reg  [15:0] shift_r;
	wire        sclk_fall;

	// ----------------------------------------
	// Pin synchroniser and falling edge
	// ----------------------------------------
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sclk_m_r <= 1'b0;
			sclk_s_r <= 1'b0;
			sclk_d_r <= 1'b0;
		end
		else
		begin
			sclk_m_r <= status_shift_clock;
			sclk_s_r <= sclk_m_r;
			sclk_d_r <= sclk_s_r;
		end
	end

	assign sclk_fall = sclk_d_r & ~sclk_s_r;

	// ----------------------------------------
	// Frame: sixteen ones, then the word MSB first
	// ----------------------------------------
	// Word is latched at its first bit so it cannot tear mid-frame
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pos_r             <= 5'h00;
			shift_r           <= 16'h0000;
			status_serial_out <= 1'b1;
		end
		else if (sclk_fall)
		begin
			pos_r <= pos_r + 5'h01;
			if (pos_r < `PSL_QS_BITS)
				status_serial_out <= 1'b1;
			else if (pos_r == `PSL_QS_BITS)
			begin
				status_serial_out <= qs_word[15];
				shift_r           <= {qs_word[14:0], 1'b0};
			end
			else
			begin
				status_serial_out <= shift_r[15];
				shift_r           <= {shift_r[14:0], 1'b0};
			end
		end
	end
endmodule // psl_status_serial_out

/* File: psl_monitor_sva.sv */
// Assertion checker for the status LED monitor, bound to its ports
`timescale 1ns/1ps
module psl_monitor_sva #(
	parameter MS_CYCLES = 10
) (
	// Clock and reset
	input wire       clk,
	input wire       resetn,
	// Inputs watched
	input wire       rx_active,
	input wire       link_up,
	input wire       an_complete,
	input wire       an_start,
	input wire       page_rx_evt,
	input wire       base_page_evt,
	input wire       page_flags_read,
	input wire [3:0] led1_sel,
	input wire       stretch_en,
	input wire       alt_next_page_en,
	input wire       hw_ctrl_mode,
	input wire       status_shift_clock,
	// Outputs judged
	input wire       an_done,
	input wire       link_status_basic,
	input wire       link_status_quick,
	input wire       page_received,
	input wire       base_page,
	input wire [2:0] led_out,
	input wire [2:0] led_oe,
	input wire       status_serial_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	integer   up_r;
	reg [5:0] fall_r;
	reg       sck_r;
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Age since reset and a short history of shift clock falls
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			up_r   <= 0;
			fall_r <= 6'h00;
			sck_r  <= 1'b1;
		end
		else
		begin
			if (up_r < 1000 * MS_CYCLES)
				up_r <= up_r + 1;
			fall_r <= {fall_r[4:0], sck_r & ~status_shift_clock};
			sck_r  <= status_shift_clock;
		end
	end
	// Stretched pulse: the LED comes on soon and stays on for eight cycles
	sequence s_rx_rise;
		stretch_en && led1_sel == 4'h2 && $rose(rx_active);
	endsequence
	sequence s_held;
		led_out[0] [*8];
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_lamp_on: assert property (up_r < 980 * MS_CYCLES |-> led_out == 3'h7)
		else $error("lamp test ended early");
	chk_stretch_hold: assert property (s_rx_rise |-> ##[1:3] s_held)
		else $error("stretched pulse not held");
	chk_done_flag: assert property ($past(resetn) |-> an_done == $past(an_complete))
		else $error("negotiation done flag wrong");
	chk_link_flags: assert property ($past(resetn) |->
		link_status_basic == $past(link_up) && link_status_quick == link_status_basic)
		else $error("link flags wrong");
	chk_page_set: assert property (page_rx_evt |=> page_received)
		else $error("page flag not set");
	chk_page_keep: assert property (page_received && !page_flags_read
		&& !(alt_next_page_en && an_start) |=> page_received)
		else $error("page flag lost");
	chk_alt_clear: assert property (alt_next_page_en && an_start && !page_rx_evt
		|=> !page_received)
		else $error("page flag kept on restart");
	chk_base_set: assert property (base_page_evt |=> base_page)
		else $error("base page flag not set");
	chk_read_clear: assert property (page_flags_read && !page_rx_evt && !base_page_evt
		|=> !page_received && !base_page)
		else $error("read did not clear flags");
	chk_qs_timing: assert property ($changed(status_serial_out) |-> |fall_r)
		else $error("serial bit moved off a shift clock fall");
	chk_drive_on: assert property ($past(resetn) && !hw_ctrl_mode |-> led_oe == 3'h7)
		else $error("LED pins not driven");
endmodule // psl_monitor_sva

bind psl_monitor psl_monitor_sva #(.MS_CYCLES(MS_CYCLES)) i_psl_monitor_sva (
	.clk, .resetn, .rx_active, .link_up, .an_complete, .an_start, .page_rx_evt,
	.base_page_evt, .page_flags_read, .led1_sel, .stretch_en, .alt_next_page_en,
	.hw_ctrl_mode, .status_shift_clock, .an_done, .link_status_basic,
	.link_status_quick, .page_received, .base_page, .led_out, .led_oe, .status_serial_out
);

/* File: psl_qs_host.sv */
// Quick-status receiver model standing in for the switch controller
`timescale 1ns/1ps
module psl_qs_host (
	// Controller reset
	input wire        resetn,
	// Quick-status link
	output reg        status_shift_clock,
	input wire        status_serial_out,
	// Frames received
	output reg [15:0] word_r,
	output reg        sig_ok_r,
	output reg [7:0]  words_r
);
	integer n;
	integer hold_r;
	// ----------------------------------------
	// Shift clock and framing
	// ----------------------------------------
	initial
	begin
		status_shift_clock = 1'b1;
		sig_ok_r = 1'b1;
		words_r = 8'h00;
		word_r = 16'h0000;
		hold_r = 2;
		n = 0;
	end
	// 5 MHz clock; held high in reset and for a while after, so no fall races release
	always
	begin
		#100;
		if (!resetn)
		begin
			status_shift_clock = 1'b1;
			hold_r = 2;
		end
		else if (hold_r > 0)
			hold_r = hold_r - 1;
		else
			status_shift_clock = ~status_shift_clock;
	end
	// Each fall samples the bit launched one fall earlier, long settled by now
	always @(negedge status_shift_clock or negedge resetn)
	begin
		if (!resetn)
			n = 0;
		else
		begin
			if (n > 0 && (n - 1) % 32 < 16 && status_serial_out !== 1'b1)
				sig_ok_r = 1'b0;
			else if (n > 0)
				word_r = {word_r[14:0], status_serial_out};
			if (n > 0 && (n - 1) % 32 == 31)
				words_r = words_r + 8'h01;
			n = n + 1;
		end
	end
endmodule // psl_qs_host

/* File: test_psl_monitor.sv */
// Self-checking testbench for the status LED and quick-status monitor
`timescale 1ns/1ps
module test_psl_monitor;
	reg        clk, resetn, link_up, speed_100, duplex_full, tx_active, rx_active;
	reg        collision, polarity_ok, an_complete, an_start, page_rx_evt;
	reg        base_page_evt, page_flags_read, stretch_en, alt_next_page_en, hw_ctrl_mode;
	reg [3:0]  led1_sel, led2_sel, led3_sel;
	reg [1:0]  stretch_len;
	reg [2:0]  led_in;
	wire       an_done, link_status_basic, link_status_quick, page_received, base_page;
	wire [2:0] led_out, led_oe, hw_strap;
	wire       status_shift_clock, status_serial_out, sig_ok_r;
	wire [15:0] word_r;
	wire [7:0] words_r;
	integer    failures, n_compared, ticks;
	// ----------------------------------------
	// Design and controller model
	// ----------------------------------------
	psl_monitor #(.MS_CYCLES(10)) i_psl_monitor (.clk, .resetn, .link_up, .speed_100,
		.duplex_full, .tx_active, .rx_active, .collision, .polarity_ok, .an_complete,
		.an_start, .page_rx_evt, .base_page_evt, .page_flags_read, .led1_sel, .led2_sel,
		.led3_sel, .stretch_en, .stretch_len, .alt_next_page_en, .hw_ctrl_mode, .an_done,
		.link_status_basic, .link_status_quick, .page_received, .base_page, .led_in,
		.led_out, .led_oe, .hw_strap, .status_shift_clock, .status_serial_out);
	psl_qs_host i_psl_qs_host (.resetn, .status_shift_clock, .status_serial_out, .word_r,
		.sig_ok_r, .words_r);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard, well above the expected run of some 16000 cycles
	always @(posedge clk)
	begin
		ticks = ticks + 1;
		if (ticks == 40000)
		begin
			failures = failures + 1;
			give_verdict;
		end
	end
	task cyc(input integer k);
		repeat (k) @(negedge clk);
	endtask
	task check(input [15:0] seen, input [15:0] exp);
	begin
		n_compared = n_compared + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// Bit c of v is the condition shown by selection code c
	task set_cond(input [5:0] v);
		{duplex_full, link_up, collision, rx_active, tx_active, speed_100} = v;
	endtask
	task pulse_rx;
	begin
		rx_active = 1'b1;
		cyc(1);
		rx_active = 1'b0;
	end
	endtask
	task give_verdict;
	begin
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_lamp;
	begin
		cyc(2);
		check(led_out, 3'h7);
		cyc(9800);
		check(led_out, 3'h7);
		cyc(300);
		check(led_out, 3'h0);
	end
	endtask
	task t_flags;
	begin
		an_complete = 1'b1;
		link_up = 1'b1;
		cyc(2);
		check({an_done, link_status_basic, link_status_quick}, 3'h7);
		page_rx_evt = 1'b1;
		base_page_evt = 1'b1;
		cyc(1);
		page_rx_evt = 1'b0;
		base_page_evt = 1'b0;
		an_start = 1'b1;
		cyc(1);
		an_start = 1'b0;
		cyc(3);
		check({page_received, base_page}, 2'h3);
		page_flags_read = 1'b1;
		cyc(1);
		page_flags_read = 1'b0;
		cyc(1);
		check({page_received, base_page}, 2'h0);
		alt_next_page_en = 1'b1;
		page_rx_evt = 1'b1;
		cyc(1);
		page_rx_evt = 1'b0;
		an_start = 1'b1;
		cyc(1);
		an_start = 1'b0;
		cyc(1);
		check(page_received, 1'b0);
		alt_next_page_en = 1'b0;
		link_up = 1'b0;
	end
	endtask
	task t_select;
		integer c;
	begin
		led2_sel = 4'hE;
		for (c = 0; c < 6; c = c + 1)
		begin
			led1_sel = c[3:0];
			set_cond(6'h01 << c);
			cyc(4);
			check(led_out, 3'h3);
			set_cond(6'h00);
			cyc(4);
			check(led_out, 3'h2);
		end
		led1_sel = 4'hF;
		led3_sel = 4'h4;
		set_cond(6'h10);
		cyc(4);
		check(led_out, 3'h6);
		led3_sel = 4'hF;
		set_cond(6'h00);
	end
	endtask
	task t_stretch;
		integer c;
	begin
		stretch_en = 1'b1;
		led1_sel = 4'h2;
		led2_sel = 4'hF;
		for (c = 0; c < 4; c = c + 1)
		begin
			stretch_len = c[1:0];
			pulse_rx;
			cyc((c == 0 ? 300 : c == 1 ? 600 : 1000) - 15);
			check(led_out[0], 1'b1);
			cyc(30);
			check(led_out[0], 1'b0);
		end
		stretch_len = 2'h0;
		pulse_rx;
		cyc(200);
		pulse_rx;
		cyc(250);
		check(led_out[0], 1'b1);
		cyc(60);
		check(led_out[0], 1'b0);
		led2_sel = 4'h5;
		duplex_full = 1'b1;
		cyc(700);
		check(led_out[1], 1'b1);
		duplex_full = 1'b0;
		cyc(320);
		check(led_out[1], 1'b0);
		stretch_en = 1'b0;
		led2_sel = 4'hF;
	end
	endtask
	task t_blink;
		integer k, ones;
	begin
		led1_sel = 4'hD;
		ones = 0;
		cyc(4);
		check(led_out[0], 1'b0);
		link_up = 1'b1;
		cyc(4);
		check(led_out[0], 1'b1);
		tx_active = 1'b1;
		for (k = 0; k < 80; k = k + 1)
		begin
			cyc(10);
			ones = ones + led_out[0];
		end
		check(ones > 10 && ones < 70, 1'b1);
		tx_active = 1'b0;
		cyc(400);
		check(led_out[0], 1'b1);
		led1_sel = 4'hF;
	end
	endtask
	task t_quick;
		integer k;
		reg [7:0] w0;
	begin
		set_cond(6'h1D);
		w0 = words_r;
		k = 0;
		while (words_r != w0 + 8'h02 && k < 1000)
		begin
			cyc(1);
			k = k + 1;
		end
		check(k < 1000, 1'b1);
		// Page flags and the restart pulse are all clear by now
		check(word_r, {rx_active, tx_active, collision, link_up, duplex_full, speed_100,
			an_complete, 3'h0, polarity_ok, 5'h00});
		check(sig_ok_r, 1'b1);
		set_cond(6'h00);
	end
	endtask
	task t_strap;
	begin
		resetn = 1'b0;
		hw_ctrl_mode = 1'b1;
		led_in = 3'h6;
		cyc(16);
		resetn = 1'b1;
		cyc(2);
		check(led_oe, 3'h0);
		cyc(30);
		check(hw_strap, 3'h6);
	end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		resetn = 1'b0;
		set_cond(6'h00);
		{polarity_ok, an_complete, an_start, page_rx_evt} = 4'h8;
		{base_page_evt, page_flags_read, stretch_en, alt_next_page_en} = 4'h0;
		{led1_sel, led2_sel, led3_sel} = 12'hFFF;
		stretch_len = 2'h0;
		hw_ctrl_mode = 1'b0;
		led_in = 3'h5;
		failures = 0;
		n_compared = 0;
		ticks = 0;
		cyc(16);
		resetn = 1'b1;
		t_lamp;
		t_flags;
		t_select;
		t_stretch;
		t_blink;
		t_quick;
		t_strap;
		give_verdict;
	end
endmodule // test_psl_monitor
